/* File: pkg/sir_pkg.sv */
// ----------------------------------------------------------------
// switch ingress rule constants
// ----------------------------------------------------------------
package sir_pkg;

  // register indices; byte address is four times the index
  localparam logic [13:0] SIR_GLOBAL_IDX  = 14'h1840;
  localparam logic [13:0] SIR_PORTCFG_IDX = 14'h1841;
  localparam logic [13:0] SIR_TAGONLY_IDX = 14'h1842;
  localparam logic [13:0] SIR_STP_IDX     = 14'h1843;
  localparam logic [13:0] SIR_PRIQ_IDX    = 14'h1845;
  localparam logic [13:0] SIR_ADMITNM_IDX = 14'h1849;
  localparam logic [13:0] SIR_STATUS_IDX  = 14'h1850;

  // global ingress config field positions
  localparam int SIR_GLB_VLAN_EN_BIT = 0;
  localparam int SIR_GLB_VL_PREC_BIT = 1;
  localparam int SIR_GLB_IP_PRIORITY_SELECT_BIT  = 9;

  // port ingress config field positions
  localparam int SIR_PCFG_MBR_LSB   = 0;
  localparam int SIR_PCFG_LEARN_LSB = 3;

  // reset values
  localparam logic [31:0] SIR_GLOBAL_RST  = 32'h0000_0002;
  localparam logic [5:0]  SIR_PORTCFG_RST = 6'h38;
  localparam logic [2:0]  SIR_TAGONLY_RST = 3'h0;
  localparam logic [5:0]  SIR_STP_RST     = 6'h00;
  localparam logic [15:0] SIR_PRIQ_RST    = 16'hFA41;
  localparam logic [2:0]  SIR_ADMITNM_RST = 3'h0;

  // spanning tree state codes
  localparam logic [1:0] SIR_STP_FWD    = 2'h0;
  localparam logic [1:0] SIR_STP_BLOCK  = 2'h1;
  localparam logic [1:0] SIR_STP_LEARN  = 2'h2;
  localparam logic [1:0] SIR_STP_LISTEN = 2'h3;

  // one bit per port: bit p belongs to port p
  function automatic logic sir_port_bit(input logic [2:0] v, input logic [1:0] p);
    sir_port_bit = (p <= 2'd2) ? v[p] : 1'b0;
  endfunction

  // two-bit state per port at bits 2p+1:2p
  function automatic logic [1:0] sir_stp_of(input logic [5:0] v, input logic [1:0] p);
    sir_stp_of = (p <= 2'd2) ? v[2*p +: 2] : SIR_STP_BLOCK;
  endfunction

  // traffic class of priority p at bits 2p+1:2p
  function automatic logic [1:0] sir_queue_of(input logic [15:0] m, input logic [2:0] p);
    sir_queue_of = m[2*p +: 2];
  endfunction

endpackage

/* File: src/sir_ingress_rules.sv */
// Our own choice: the Wishbone register port.
`timescale 1ns/1ps
`default_nettype none
module sir_ingress_rules
  import sir_pkg::*;
#(
  parameter int CNT_W = 16
) (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [15:0] wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // packet attributes from parser and lookup
  input  wire logic        pkt_valid_i,
  input  wire logic [1:0]  pkt_port_i,
  input  wire logic        pkt_tagged_i,
  input  wire logic        pkt_vid_zero_i,
  input  wire logic [2:0]  pkt_vlan_prio_i,
  input  wire logic        pkt_is_ip_i,
  input  wire logic [2:0]  pkt_ip_prio_i,
  input  wire logic [2:0]  pkt_default_prio_i,
  input  wire logic        pkt_vlan_active_i,
  input  wire logic [2:0]  pkt_vlan_members_i,
  input  wire logic        pkt_da_found_i,
  input  wire logic [1:0]  pkt_egress_port_i,
  // ingress decision
  output logic             dec_valid_o,
  output logic             dec_drop_o,
  output logic             dec_learn_o,
  output logic      [2:0]  dec_prio_o,
  output logic      [1:0]  dec_queue_o
);

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic             vlan_en_ff;
  logic             vl_prec_ff;
  logic             ip_priority_select_ff;
  logic [5:0]       portcfg_ff;
  logic [2:0]       tagonly_ff;
  logic [5:0]       stp_ff;
  logic [15:0]      priq_ff;
  logic [2:0]       admitnm_ff;
  logic [CNT_W-1:0] drop_cnt_ff;
  logic [CNT_W-1:0] learn_cnt_ff;

  logic [2:0]  mbr_chk;
  logic [2:0]  learn_en;
  logic [13:0] wb_idx;
  logic        wb_req;
  logic        wb_wr;
  logic [31:0] nxt_rdata;

  assign mbr_chk  = portcfg_ff[SIR_PCFG_MBR_LSB +: 3];
  assign learn_en = portcfg_ff[SIR_PCFG_LEARN_LSB +: 3];
  assign wb_idx   = wb_adr_i[15:2];
  assign wb_req   = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wb_wr    = wb_req && wb_we_i;

  // ----------------------------------------------------------------
  // bus handshake
  // ----------------------------------------------------------------
  // one wait-free cycle; ack drops the cycle after it was given
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= wb_req;
    end
  end

  // ----------------------------------------------------------------
  // configuration writes
  // ----------------------------------------------------------------
  // global bits live in lanes 0 and 1
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      vl_prec_ff <= SIR_GLOBAL_RST[SIR_GLB_VL_PREC_BIT];
      vlan_en_ff <= SIR_GLOBAL_RST[SIR_GLB_VLAN_EN_BIT];
      ip_priority_select_ff  <= SIR_GLOBAL_RST[SIR_GLB_IP_PRIORITY_SELECT_BIT];
    end else if (wb_wr && wb_idx == SIR_GLOBAL_IDX) begin
      if (wb_sel_i[0]) begin
        vlan_en_ff <= wb_dat_i[SIR_GLB_VLAN_EN_BIT];
        vl_prec_ff <= wb_dat_i[SIR_GLB_VL_PREC_BIT];
      end
      if (wb_sel_i[1]) begin
        ip_priority_select_ff <= wb_dat_i[SIR_GLB_IP_PRIORITY_SELECT_BIT];
      end
    end
  end

  // per-port fields all sit in lane 0
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      portcfg_ff <= SIR_PORTCFG_RST;
      tagonly_ff <= SIR_TAGONLY_RST;
      stp_ff     <= SIR_STP_RST;
      admitnm_ff <= SIR_ADMITNM_RST;
    end else if (wb_wr && wb_sel_i[0]) begin
      case (wb_idx)
        SIR_PORTCFG_IDX: portcfg_ff <= wb_dat_i[5:0];
        SIR_TAGONLY_IDX: tagonly_ff <= wb_dat_i[2:0];
        SIR_STP_IDX:     stp_ff     <= wb_dat_i[5:0];
        SIR_ADMITNM_IDX: admitnm_ff <= wb_dat_i[2:0];
        default: ;
      endcase
    end
  end

  // class table spans two byte lanes
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      priq_ff <= SIR_PRIQ_RST;
    end else if (wb_wr && wb_idx == SIR_PRIQ_IDX) begin
      if (wb_sel_i[0]) begin
        priq_ff[7:0] <= wb_dat_i[7:0];
      end
      if (wb_sel_i[1]) begin
        priq_ff[15:8] <= wb_dat_i[15:8];
      end
    end
  end

  // ----------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------
  // unmapped words and reserved bits read zero
  always_comb begin
    nxt_rdata = 32'h0000_0000;
    case (wb_idx)
      SIR_GLOBAL_IDX: begin
        nxt_rdata[SIR_GLB_VLAN_EN_BIT] = vlan_en_ff;
        nxt_rdata[SIR_GLB_VL_PREC_BIT] = vl_prec_ff;
        nxt_rdata[SIR_GLB_IP_PRIORITY_SELECT_BIT]  = ip_priority_select_ff;
      end
      SIR_PORTCFG_IDX: nxt_rdata[5:0]  = portcfg_ff;
      SIR_TAGONLY_IDX: nxt_rdata[2:0]  = tagonly_ff;
      SIR_STP_IDX:     nxt_rdata[5:0]  = stp_ff;
      SIR_PRIQ_IDX:    nxt_rdata[15:0] = priq_ff;
      SIR_ADMITNM_IDX: nxt_rdata[2:0]  = admitnm_ff;
      SIR_STATUS_IDX: begin
        nxt_rdata[15:0]  = 16'(drop_cnt_ff);
        nxt_rdata[31:16] = 16'(learn_cnt_ff);
      end
      default: nxt_rdata = 32'h0000_0000;
    endcase
  end

  // data held only with ack, zero otherwise
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (wb_req && !wb_we_i) begin
      wb_dat_o <= nxt_rdata;
    end else begin
      wb_dat_o <= 32'h0000_0000;
    end
  end

  // ----------------------------------------------------------------
  // ingress rule evaluation
  // ----------------------------------------------------------------
  logic [1:0] port_state;
  logic       stp_pass;
  logic       stp_learn;
  logic       tag_fail;
  logic       ingress_fail;
  logic       egress_fail;
  logic       nxt_drop;
  logic       nxt_learn;
  logic [2:0] sel_prio;
  logic [1:0] sel_queue;

  assign port_state = sir_stp_of(stp_ff, pkt_port_i);
  assign stp_pass   = (port_state == SIR_STP_FWD);
  assign stp_learn  = (port_state == SIR_STP_FWD) || (port_state == SIR_STP_LEARN);

  assign tag_fail = sir_port_bit(tagonly_ff, pkt_port_i)
                    && (!pkt_tagged_i || pkt_vid_zero_i);

  // nonmember ingress, admit needs active vlan
  assign ingress_fail = !sir_port_bit(pkt_vlan_members_i, pkt_port_i)
                        && !(sir_port_bit(admitnm_ff, pkt_port_i) && pkt_vlan_active_i);

  // egress checked only for a known destination
  assign egress_fail = pkt_da_found_i
                       && !sir_port_bit(pkt_vlan_members_i, pkt_egress_port_i);

  // vlan rules gated by global enable
  always_comb begin
    nxt_drop = !stp_pass;
    if (vlan_en_ff) begin
      if (sir_port_bit(mbr_chk, pkt_port_i) && (ingress_fail || egress_fail)) begin
        nxt_drop = 1'b1;
      end
      if (tag_fail) begin
        nxt_drop = 1'b1;
      end
    end
  end

  // learn needs enable and a learning state
  // learning bit p gates port p
  assign nxt_learn = sir_port_bit(learn_en, pkt_port_i) && stp_learn;

  // tag priority used only with vlan on
  sir_prio_select u_prio (
    .vlan_en_i      (vlan_en_ff),
    .vl_prec_i      (vl_prec_ff),
    .ip_priority_select_i       (ip_priority_select_ff),
    .queue_map_i    (priq_ff),
    .tagged_i       (pkt_tagged_i),
    .is_ip_i        (pkt_is_ip_i),
    .vlan_prio_i    (pkt_vlan_prio_i),
    .ip_prio_i      (pkt_ip_prio_i),
    .default_prio_i (pkt_default_prio_i),
    .prio_o         (sel_prio),
    .queue_o        (sel_queue)
  );

  // ----------------------------------------------------------------
  // decision outputs
  // ----------------------------------------------------------------
  // one cycle after the packet strobe, held zero between packets
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dec_valid_o <= 1'b0;
      dec_drop_o  <= 1'b0;
      dec_learn_o <= 1'b0;
      dec_prio_o  <= 3'h0;
      dec_queue_o <= 2'h0;
    end else begin
      dec_valid_o <= pkt_valid_i;
      dec_drop_o  <= pkt_valid_i && nxt_drop;
      dec_learn_o <= pkt_valid_i && nxt_learn;
      dec_prio_o  <= pkt_valid_i ? sel_prio : 3'h0;
      dec_queue_o <= pkt_valid_i ? sel_queue : 2'h0;
    end
  end

  // saturating counters, so software sees a ceiling, not a wrap
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      drop_cnt_ff  <= '0;
      learn_cnt_ff <= '0;
    end else begin
      if (dec_valid_o && dec_drop_o && !(&drop_cnt_ff)) begin
        drop_cnt_ff <= drop_cnt_ff + 1'b1;
      end
      if (dec_valid_o && dec_learn_o && !(&learn_cnt_ff)) begin
        learn_cnt_ff <= learn_cnt_ff + 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // bus answers in exactly one cycle, then drops
  bus_ack_time_a: assert property (
    (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o ##1 !wb_ack_o
  ) else $error("ack not a single cycle after request");

  // defaults after reset release
  reset_values_a: assert property (
    $fell(rst_i) |-> (priq_ff == SIR_PRIQ_RST) && vl_prec_ff && !vlan_en_ff
                     && (stp_ff == SIR_STP_RST) && (learn_en == 3'h7)
  ) else $error("reset values wrong");

  // blocked or listening ports never pass or learn
  stp_block_a: assert property (
    (pkt_valid_i && port_state[0])
      |=> dec_valid_o && dec_drop_o && !dec_learn_o
  ) else $error("blocked port forwarded or learned");

  // learning follows enable and state
  learn_gate_a: assert property (
    pkt_valid_i |=> dec_learn_o == ($past(sir_port_bit(learn_en, pkt_port_i))
      && !$past(port_state[0]))
  ) else $error("learn decision wrong");

  // vlan rules silent while disabled
  vlan_gate_a: assert property (
    (pkt_valid_i && !vlan_en_ff && sir_stp_of(stp_ff, pkt_port_i) == SIR_STP_FWD)
      |=> !dec_drop_o
  ) else $error("dropped with vlan disabled");

  // tagged-only rejection
  tag_only_a: assert property (
    (pkt_valid_i && vlan_en_ff && sir_port_bit(tagonly_ff, pkt_port_i)
      && (!pkt_tagged_i || pkt_vid_zero_i)) |=> dec_drop_o
  ) else $error("untagged frame admitted");

  // nonmember ingress drop
  ingress_member_a: assert property (
    (pkt_valid_i && vlan_en_ff && sir_port_bit(mbr_chk, pkt_port_i)
      && !sir_port_bit(pkt_vlan_members_i, pkt_port_i)
      && !sir_port_bit(admitnm_ff, pkt_port_i)) |=> dec_drop_o
  ) else $error("nonmember ingress admitted");

  // nonmember egress drop for known destination
  egress_member_a: assert property (
    (pkt_valid_i && vlan_en_ff && sir_port_bit(mbr_chk, pkt_port_i) && pkt_da_found_i
      && !sir_port_bit(pkt_vlan_members_i, pkt_egress_port_i)) |=> dec_drop_o
  ) else $error("nonmember egress admitted");

  // queue taken from class table
  queue_map_a: assert property (
    dec_valid_o |-> dec_queue_o == sir_queue_of($past(priq_ff), dec_prio_o)
  ) else $error("queue not from class table");

  // tag priority over ip when precedence set
  vlan_prec_a: assert property (
    (pkt_valid_i && vlan_en_ff && vl_prec_ff && pkt_tagged_i)
      |=> dec_prio_o == $past(pkt_vlan_prio_i)
  ) else $error("vlan priority not chosen");

  // ip priority when vlan off and ip_priority_select set
  ip_prio_a: assert property (
    (pkt_valid_i && !vlan_en_ff && ip_priority_select_ff && pkt_is_ip_i)
      |=> dec_prio_o == $past(pkt_ip_prio_i)
  ) else $error("ip priority not chosen");

  // main scenarios
  membership_drop_c: cover property (
    pkt_valid_i && vlan_en_ff && sir_port_bit(mbr_chk, pkt_port_i) && ingress_fail
  );
  admit_nonmember_c: cover property (
    pkt_valid_i && vlan_en_ff && sir_port_bit(admitnm_ff, pkt_port_i)
    && pkt_vlan_active_i ##1 dec_valid_o && !dec_drop_o
  );
  learn_state_c: cover property (
    pkt_valid_i && sir_stp_of(stp_ff, pkt_port_i) == SIR_STP_LEARN ##1 dec_learn_o
  );
  reg_write_c: cover property (wb_wr && wb_idx == SIR_PRIQ_IDX);

endmodule
`default_nettype wire

/* File: src/sir_prio_select.sv */
`timescale 1ns/1ps
`default_nettype none
module sir_prio_select
  import sir_pkg::*;
(
  // configuration
  input  wire logic        vlan_en_i,
  input  wire logic        vl_prec_i,
  input  wire logic        ip_priority_select_i,
  input  wire logic [15:0] queue_map_i,
  // packet attributes
  input  wire logic        tagged_i,
  input  wire logic        is_ip_i,
  input  wire logic [2:0]  vlan_prio_i,
  input  wire logic [2:0]  ip_prio_i,
  input  wire logic [2:0]  default_prio_i,
  // result
  output logic      [2:0]  prio_o,
  output logic      [1:0]  queue_o
);

  logic vlan_ok;
  logic ip_ok;

  // ----------------------------------------------------------------
  // priority source
  // ----------------------------------------------------------------
  assign vlan_ok = vlan_en_i && tagged_i;
  assign ip_ok   = ip_priority_select_i && is_ip_i;

  // vlan tag wins over ip field only when precedence bit is set
  always_comb begin
    if (vlan_ok && (vl_prec_i || !ip_ok)) begin
      prio_o = vlan_prio_i;
    end else if (ip_ok) begin
      prio_o = ip_prio_i;
    end else begin
      prio_o = default_prio_i;
    end
  end

  assign queue_o = sir_queue_of(queue_map_i, prio_o);

endmodule
`default_nettype wire

/* File: verification/test_switch_ingress_vlan_stp_rules.sv */
`timescale 1ns/1ps
`default_nettype none
module test_switch_ingress_vlan_stp_rules;
  import sir_pkg::*;

  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic        clk_i;
  logic        rst_i;
  logic        wb_cyc_i;
  logic        wb_stb_i;
  logic        wb_we_i;
  logic [15:0] wb_adr_i;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  logic        pkt_valid_i;
  logic [1:0]  pkt_port_i;
  logic        pkt_tagged_i;
  logic        pkt_vid_zero_i;
  logic [2:0]  pkt_vlan_prio_i;
  logic        pkt_is_ip_i;
  logic [2:0]  pkt_ip_prio_i;
  logic [2:0]  pkt_default_prio_i;
  logic        pkt_vlan_active_i;
  logic [2:0]  pkt_vlan_members_i;
  logic        pkt_da_found_i;
  logic [1:0]  pkt_egress_port_i;
  logic        dec_valid_o;
  logic        dec_drop_o;
  logic        dec_learn_o;
  logic [2:0]  dec_prio_o;
  logic [1:0]  dec_queue_o;

  // bench state: next packet attributes and mirrored configuration
  logic [1:0]  p_port;
  logic        p_tag;
  logic        p_vidz;
  logic [2:0]  p_vprio;
  logic        p_ip;
  logic [2:0]  p_ipprio;
  logic [2:0]  p_dprio;
  logic        p_act;
  logic [2:0]  p_mbr;
  logic        p_found;
  logic [1:0]  p_egr;
  logic [15:0] cur_map;
  logic [31:0] cur_glb;
  logic [31:0] rdata;
  logic [31:0] glb_tab [7];
  int          failures;
  int          total_checks;
  int          cycles;
  int          exp_drops;
  int          exp_learns;

  sir_ingress_rules DUT (
    .clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .pkt_valid_i(pkt_valid_i), .pkt_port_i(pkt_port_i), .pkt_tagged_i(pkt_tagged_i),
    .pkt_vid_zero_i(pkt_vid_zero_i), .pkt_vlan_prio_i(pkt_vlan_prio_i),
    .pkt_is_ip_i(pkt_is_ip_i), .pkt_ip_prio_i(pkt_ip_prio_i),
    .pkt_default_prio_i(pkt_default_prio_i), .pkt_vlan_active_i(pkt_vlan_active_i),
    .pkt_vlan_members_i(pkt_vlan_members_i), .pkt_da_found_i(pkt_da_found_i),
    .pkt_egress_port_i(pkt_egress_port_i),
    .dec_valid_o(dec_valid_o), .dec_drop_o(dec_drop_o), .dec_learn_o(dec_learn_o),
    .dec_prio_o(dec_prio_o), .dec_queue_o(dec_queue_o)
  );

  // ----------------------------------------------------------------
  // clock and hang guard
  // ----------------------------------------------------------------
  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  // whole run is a few hundred cycles; the ceiling leaves wide margin
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      failures = failures + 1;
      summarize();
    end
  end

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks = total_checks + 1;
    if (seen !== exp) begin
      failures = failures + 1;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic summarize();
    if (failures == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // classic single cycle; request held until ack is sampled high
  task automatic wb(input logic we, input logic [13:0] idx, input logic [3:0] sel,
                    input logic [31:0] wd, output logic [31:0] rd);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= {idx, 2'b00};
    wb_sel_i <= sel;
    wb_dat_i <= wd;
    @(posedge clk_i);
    // only the bench ceiling ends a wait that never sees ack
    while (wb_ack_o !== 1'b1) begin
      @(posedge clk_i);
    end
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
  endtask

  task automatic wr(input logic [13:0] idx, input logic [31:0] wd);
    logic [31:0] d;
    wb(1'b1, idx, 4'hF, wd, d);
  endtask

  task automatic rchk(input logic [13:0] idx, input logic [31:0] exp);
    logic [31:0] d;
    wb(1'b0, idx, 4'hF, 32'h0000_0000, d);
    check(d, exp);
  endtask

  // tag wins when vlan is on and either precedence is set or ip is not in play
  function automatic logic [2:0] eprio();
    logic ipsel;
    ipsel = cur_glb[9] && p_ip;
    if (cur_glb[0] && p_tag && (cur_glb[1] || !ipsel)) eprio = p_vprio;
    else if (ipsel) eprio = p_ipprio;
    else eprio = p_dprio;
  endfunction

  // one decision, answered exactly one cycle after the valid pulse
  task automatic pkt(input logic exp_drop, input logic exp_learn);
    logic [2:0] pr;
    pr = eprio();
    @(posedge clk_i);
    pkt_valid_i <= 1'b1;
    {pkt_port_i, pkt_tagged_i} <= {p_port, p_tag};
    {pkt_vid_zero_i, pkt_vlan_prio_i} <= {p_vidz, p_vprio};
    {pkt_is_ip_i, pkt_ip_prio_i, pkt_default_prio_i} <= {p_ip, p_ipprio, p_dprio};
    {pkt_vlan_active_i, pkt_vlan_members_i} <= {p_act, p_mbr};
    {pkt_da_found_i, pkt_egress_port_i} <= {p_found, p_egr};
    @(posedge clk_i);
    pkt_valid_i <= 1'b0;
    @(posedge clk_i);
    check({28'h0, dec_valid_o, dec_drop_o, dec_learn_o, 1'b0},
          {28'h0, 1'b1, exp_drop, exp_learn, 1'b0});
    check({27'h0, dec_prio_o, dec_queue_o}, {27'h0, pr, cur_map[2*pr +: 2]});
    // running totals mirrored for the status word
    exp_drops  = exp_drops + int'(exp_drop);
    exp_learns = exp_learns + int'(exp_learn);
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} = '0;
    {pkt_valid_i, pkt_port_i, pkt_tagged_i, pkt_vid_zero_i, pkt_vlan_prio_i} = '0;
    {pkt_is_ip_i, pkt_ip_prio_i, pkt_default_prio_i, pkt_vlan_active_i} = '0;
    {pkt_vlan_members_i, pkt_da_found_i, pkt_egress_port_i} = '0;
    {p_port, p_tag, p_vidz, p_vprio, p_ip, p_ipprio, p_dprio} = '0;
    {p_act, p_mbr, p_found, p_egr} = '0;
    glb_tab = '{32'h203, 32'h201, 32'h200, 32'h003, 32'h001, 32'h000, 32'h202};
    cur_map = 16'hFA41;
    cur_glb = 32'h2;
    failures = 0;
    total_checks = 0;
    cycles = 0;
    exp_drops = 0;
    exp_learns = 0;
    rst_i = 1'b1;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    // reset values, then an unmapped index that must stay zero
    rchk(SIR_GLOBAL_IDX, 32'h0000_0002);
    rchk(SIR_PORTCFG_IDX, 32'h0000_0038);
    rchk(SIR_TAGONLY_IDX, 32'h0000_0000);
    rchk(SIR_STP_IDX, 32'h0000_0000);
    rchk(SIR_PRIQ_IDX, 32'h0000_FA41);
    rchk(SIR_ADMITNM_IDX, 32'h0000_0000);
    wr(14'h1844, 32'hFFFF_FFFF);
    rchk(14'h1844, 32'h0000_0000);
    // class table at reset, a rewritten table, then a lane-0-only write
    for (int p = 0; p < 8; p++) begin
      p_dprio = 3'(p);
      pkt(1'b0, 1'b1);
    end
    wr(SIR_PRIQ_IDX, 32'h0000_1B6C);
    rchk(SIR_PRIQ_IDX, 32'h0000_1B6C);
    wb(1'b1, SIR_PRIQ_IDX, 4'h1, 32'h0000_FFFF, rdata);
    rchk(SIR_PRIQ_IDX, 32'h0000_1BFF);
    cur_map = 16'h1BFF;
    for (int p = 0; p < 8; p++) begin
      p_dprio = 3'(p);
      pkt(1'b0, 1'b1);
    end
    // every spanning tree code on every port field
    for (int pt = 0; pt < 3; pt++) begin
      for (int st = 0; st < 4; st++) begin
        wr(SIR_STP_IDX, 32'(st) << (2 * pt));
        p_port = 2'(pt);
        pkt(st != 0, st == 0 || st == 2);
      end
    end
    wr(SIR_STP_IDX, 32'h0);
    // learning enable bit per port
    for (int en = 0; en < 8; en++) begin
      wr(SIR_PORTCFG_IDX, 32'(en) << 3);
      for (int pt = 0; pt < 3; pt++) begin
        p_port = 2'(pt);
        pkt(1'b0, en[pt]);
      end
    end
    // membership checks ignored while vlan is off
    wr(SIR_PORTCFG_IDX, 32'h3F);
    p_port = 2'd1;
    pkt(1'b0, 1'b1);
    // lane 1 not selected, so the ip select bit stays clear
    wb(1'b1, SIR_GLOBAL_IDX, 4'h1, 32'h0000_0203, rdata);
    rchk(SIR_GLOBAL_IDX, 32'h0000_0003);
    cur_glb = 32'h3;
    pkt(1'b1, 1'b1);
    p_mbr = 3'b010;
    pkt(1'b0, 1'b1);
    {p_found, p_egr} = {1'b1, 2'd2};
    pkt(1'b1, 1'b1);
    p_egr = 2'd1;
    pkt(1'b0, 1'b1);
    {p_found, p_egr} = {1'b0, 2'd2};
    pkt(1'b0, 1'b1);
    // admit-non-member needs an active vlan and leaves the egress check alone
    p_mbr = 3'b000;
    wr(SIR_ADMITNM_IDX, 32'h2);
    p_act = 1'b1;
    pkt(1'b0, 1'b1);
    p_act = 1'b0;
    pkt(1'b1, 1'b1);
    {p_act, p_found} = 2'b11;
    pkt(1'b1, 1'b1);
    p_found = 1'b0;
    wr(SIR_PORTCFG_IDX, 32'h3C);
    p_port = 2'd1;
    pkt(1'b0, 1'b1);
    p_port = 2'd2;
    pkt(1'b1, 1'b1);
    wr(SIR_PORTCFG_IDX, 32'h38);
    p_mbr = 3'b111;
    // tagged-only admission on port 1
    wr(SIR_TAGONLY_IDX, 32'h2);
    p_port = 2'd1;
    pkt(1'b1, 1'b1);
    {p_tag, p_vidz, p_vprio} = {1'b1, 1'b1, 3'd4};
    pkt(1'b1, 1'b1);
    p_vidz = 1'b0;
    pkt(1'b0, 1'b1);
    {p_tag, p_port} = {1'b0, 2'd0};
    pkt(1'b0, 1'b1);
    wr(SIR_GLOBAL_IDX, 32'h2);
    cur_glb = 32'h2;
    p_port = 2'd1;
    pkt(1'b0, 1'b1);
    // priority source for each mix of vlan, precedence and ip select except precedence set alone
    {p_port, p_tag, p_vprio, p_ip, p_ipprio, p_dprio} = {2'd0, 1'b1, 3'd6, 1'b1, 3'd2, 3'd1};
    foreach (glb_tab[i]) begin
      wr(SIR_GLOBAL_IDX, glb_tab[i]);
      rchk(SIR_GLOBAL_IDX, glb_tab[i]);
      cur_glb = glb_tab[i];
      pkt(1'b0, 1'b1);
    end
    // status word: learn total high, drop total low
    rchk(SIR_STATUS_IDX, {16'(exp_learns), 16'(exp_drops)});
    summarize();
  end

endmodule
`default_nettype wire
